// ### rtl/dcfd_top.sv
// Purpose: channel function decoder and drive sequencer for a disk controller
// Assumes: drive inputs are asynchronous; read clock sampled every clk
// Notes: zero response is returned at function start, except buffer read (delayed) and controller status (drive status); callReady marks answer
// Contract
// RL1: falling edge is three highs then low
// RL2: sample read clock every 8 ns
// RL3: write clock 80 ns period, half duty
// RL4: selector is low eight function bits
// RL5: requester sends 011, node, pad, selector
// RL6: accept the listed octal function codes
// RL7: track variants only on second drive type
// RL8: full sector functions wait 2048 parcels
// RL9: short transfers finish after 16 parcels
// RL10: cylinder select waits for seek done
// RL11: return to zero waits for done
// RL12: select status forwards number, waits status
// RL13: general status waits for status word
// RL14: buffer echo mode until next call
// RL15: buffer read returns delayed zero parcels
// RL16: reservation functions wait for completion
// RL17: non-transfer functions: request then done
// RL18: zero response sent at function start
// RL19: controller status returns drive status
// RL20: done ends function, latches status
// RL21: unknown selector ignored, zero response
// RL22: four-sample history, one-cycle strobe
`timescale 1ns/10ps
module dcfd_top #(
   parameter logic [3:0] NODE_ADDR = 4'h0,
   parameter int LONG_COUNT = dcfd_pkg::LONG_PARCELS,
   parameter int SHORT_COUNT = dcfd_pkg::SHORT_PARCELS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic secondType,
   input wire logic reqValid,
   input wire dcfd_pkg::dcfd_req_s req,
   input wire logic callPulse,
   input wire logic readClk,
   input wire dcfd_pkg::dcfd_drv_s drv,
   output logic respValid_ff,
   output logic [15:0] resp0_ff,
   output logic [15:0] resp1_ff,
   output logic callReady_ff,
   output logic [15:0] callResp_ff,
   output logic busy_ff,
   output logic echoMode_ff,
   output logic writeClk_ff,
   output logic funcReady_ff,
   output logic [3:0] funcCode_ff,
   output logic [15:0] busOut_ff,
   output logic rdStrobe_ff,
   output logic [15:0] drvStatus_ff
);
   // ==========================================================
   // read clock sampling and edge detect
   logic [2:0] rcSync_ff;
   logic [3:0] rcHist_ff;
   dcfd_pkg::dcfd_drv_s drvS1_ff, drvS2_ff, drvS3_ff;
   logic rcFall;

   // RL2: sample every clk
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rcSync_ff <= 3'h0;
         drvS1_ff <= '0;
         drvS2_ff <= '0;
         drvS3_ff <= '0;
      end else begin
         rcSync_ff <= {rcSync_ff[1:0], readClk};
         drvS1_ff <= drv;
         drvS2_ff <= drvS1_ff;
         drvS3_ff <= drvS2_ff;
      end
   end

   // RL22: four-sample history
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rcHist_ff <= 4'h0;
      end else if (rcSync_ff[2] == rcSync_ff[1]) begin
         rcHist_ff <= {rcHist_ff[2:0], rcSync_ff[1]};
      end
   end

   // RL1: three highs then a low
   assign rcFall = (rcHist_ff[3:1] == 3'h7) && !rcHist_ff[0];

   // RL22: one-cycle capture strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdStrobe_ff <= 1'b0;
      end else begin
         rdStrobe_ff <= rcFall && !rdStrobe_ff;
      end
   end

   logic drvDone, drvData;
   // stable copies used only on the strobe
   assign drvDone = rdStrobe_ff && drvS3_ff.done;
   assign drvData = rdStrobe_ff && drvS3_ff.ready && !drvS3_ff.done;

   // ==========================================================
   // write clock divider
   logic [3:0] wDiv_ff;
   logic wRise;
   // RL3: 80 ns period, 50% duty
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wDiv_ff <= 4'h0;
         writeClk_ff <= 1'b0;
      end else if (wDiv_ff == 4'(dcfd_pkg::WCLK_HALF_CYC - 1)) begin
         wDiv_ff <= 4'h0;
         writeClk_ff <= !writeClk_ff;
      end else begin
         wDiv_ff <= wDiv_ff + 4'h1;
      end
   end
   assign wRise = (wDiv_ff == 4'(dcfd_pkg::WCLK_HALF_CYC - 1)) && !writeClk_ff;

   // ==========================================================
   // decode
   logic [7:0] sel;
   logic hdrOk;
   logic [3:0] decCode;
   dcfd_pkg::dcfd_kind_e decKind;
   logic [11:0] decCount;

   // RL4: low eight bits
   assign sel = req.p0[7:0];
   // RL5: header check
   assign hdrOk = (req.p0[dcfd_pkg::HDR_PREFIX_LSB +: 3] == dcfd_pkg::HDR_PREFIX)
      && (req.p0[dcfd_pkg::NODE_LSB +: 4] == NODE_ADDR);

   // RL6: supported codes
   always_comb begin
      decCode = dcfd_pkg::DC_ECHO;
      decKind = dcfd_pkg::K_DRIVE;
      decCount = 12'h0;
      // RL17: default has no transfer
      if (sel == 8'h00) begin
         decCode = dcfd_pkg::DC_RELEASE;
      end else if (sel == 8'h01) begin
         decCode = dcfd_pkg::DC_RELOPP;
      end else if (sel[7:3] == 5'h01) begin
         decCode = dcfd_pkg::DC_SELECT;
      end else if (sel == 8'h10) begin
         decCode = dcfd_pkg::DC_CLRFLT;
      end else if (sel == 8'h11) begin
         decCode = dcfd_pkg::DC_RESET;
      end else if (sel[7:3] == 5'h03) begin
         decCode = dcfd_pkg::DC_RTZ;
      end else if (sel[7:3] == 5'h04) begin
         decCode = dcfd_pkg::DC_SELSTS;
      end else if (sel[7:3] == 5'h05) begin
         decCode = dcfd_pkg::DC_GENSTS;
      end else if (sel[7:3] == 5'h06) begin
         decKind = dcfd_pkg::K_CTLSTS;
      end else if (sel[7:3] == 5'h07) begin
         decCode = dcfd_pkg::DC_DIAG;
      end else if (sel == 8'h40) begin
         decCode = dcfd_pkg::DC_CYL;
      end else if (sel == 8'h41) begin
         decCode = dcfd_pkg::DC_HEAD;
      end else if (sel == 8'h80 || sel == 8'h82 || sel == 8'hc0 || sel == 8'hc4) begin
         // RL8: full sector
         decCode = sel[6] ? dcfd_pkg::DC_WRITE : dcfd_pkg::DC_READ;
         decCount = 12'(LONG_COUNT - 1);
      end else if ((sel >= 8'h81 && sel <= 8'h85) || (sel >= 8'hc1 && sel <= 8'hc3)) begin
         // RL9: short transfers
         decCode = sel[6] ? dcfd_pkg::DC_WRITE : dcfd_pkg::DC_READ;
         decCount = 12'(SHORT_COUNT - 1);
      end else if (secondType && (sel == 8'h86 || sel == 8'hc6)) begin
         // RL7: track header, second type
         decCode = sel[6] ? dcfd_pkg::DC_WRITE : dcfd_pkg::DC_READ;
         decCount = 12'(SHORT_COUNT - 1);
      end else if (secondType && (sel == 8'h88 || sel == 8'h8a
            || sel == 8'hc8 || sel == 8'hcc)) begin
         // RL7: track variants, second type
         decCode = sel[6] ? dcfd_pkg::DC_WRITE : dcfd_pkg::DC_READ;
         decCount = 12'(LONG_COUNT - 1);
      end else if (sel[7:3] == 5'h15) begin
         decKind = dcfd_pkg::K_BUFRD;
      end else if (sel[7:3] == 5'h1e) begin
         decKind = dcfd_pkg::K_BUFECHO;
      end else if (sel[7:3] == 5'h1f) begin
         decCode = dcfd_pkg::DC_ECHO;
      end else begin
         // RL21: unknown selector
         decKind = dcfd_pkg::K_NONE;
      end
   end

   // ==========================================================
   // sequencer
   dcfd_pkg::dcfd_state_e state_ff;
   logic [11:0] xferCnt_ff;
   logic [7:0] dlyCnt_ff;
   logic start;
   assign start = reqValid && hdrOk && (state_ff == dcfd_pkg::ST_IDLE);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= dcfd_pkg::ST_IDLE;
         xferCnt_ff <= 12'h0;
         dlyCnt_ff <= 8'h0;
         funcReady_ff <= 1'b0;
         funcCode_ff <= 4'h0;
         busOut_ff <= 16'h0;
         echoMode_ff <= 1'b0;
         callReady_ff <= 1'b0;
         callResp_ff <= 16'h0;
      end else begin
         if (wRise) begin
            funcReady_ff <= 1'b0;
         end
         // RL14: call pulse clears echo mode
         if (callPulse) begin
            echoMode_ff <= 1'b0;
            callReady_ff <= 1'b0;
         end
         case (state_ff)
            dcfd_pkg::ST_IDLE: begin
               if (start) begin
                  if (decKind == dcfd_pkg::K_DRIVE) begin
                     callResp_ff <= req.p1;
                     funcCode_ff <= decCode;
                     // RL10: parcel three forwarded
                     // RL12: status number forwarded
                     // RL16: reservation key in parcel three
                     busOut_ff <= req.p3;
                     xferCnt_ff <= decCount;
                     state_ff <= dcfd_pkg::ST_CMD;
                  end else if (decKind == dcfd_pkg::K_BUFRD) begin
                     dlyCnt_ff <= 8'(dcfd_pkg::RESP_DELAY_CYC - 1);
                     state_ff <= dcfd_pkg::ST_DELAY;
                  end else if (decKind == dcfd_pkg::K_BUFECHO) begin
                     busOut_ff <= req.p3;
                     echoMode_ff <= 1'b1;
                  end
               end
            end
            dcfd_pkg::ST_CMD: begin
               if (wRise) begin
                  funcReady_ff <= 1'b1;
                  state_ff <= (funcCode_ff == dcfd_pkg::DC_READ
                     || funcCode_ff == dcfd_pkg::DC_WRITE)
                     ? dcfd_pkg::ST_XFER : dcfd_pkg::ST_WAIT;
               end
            end
            dcfd_pkg::ST_XFER: begin
               // RL8: count parcels
               // RL9: count parcels
               if (drvDone) begin
                  state_ff <= dcfd_pkg::ST_IDLE;
                  callReady_ff <= 1'b1;
               end else if (drvData) begin
                  if (xferCnt_ff == 12'h0) begin
                     state_ff <= dcfd_pkg::ST_WAIT;
                  end else begin
                     xferCnt_ff <= xferCnt_ff - 12'h1;
                  end
               end
            end
            dcfd_pkg::ST_WAIT: begin
               // RL11: wait for done
               // RL13: wait for status done
               // RL20: done ends function
               if (drvDone) begin
                  state_ff <= dcfd_pkg::ST_IDLE;
                  callReady_ff <= 1'b1;
               end
            end
            dcfd_pkg::ST_DELAY: begin
               if (dlyCnt_ff == 8'h0) begin
                  state_ff <= dcfd_pkg::ST_IDLE;
               end else begin
                  dlyCnt_ff <= dlyCnt_ff - 8'h1;
               end
            end
            default: begin
               state_ff <= dcfd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // response parcels and status holding
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         respValid_ff <= 1'b0;
         resp0_ff <= 16'h0;
         resp1_ff <= 16'h0;
      end else begin
         respValid_ff <= 1'b0;
         if (start && decKind == dcfd_pkg::K_CTLSTS) begin
            // RL19: drive status in parcel zero
            respValid_ff <= 1'b1;
            resp0_ff <= drvStatus_ff;
            resp1_ff <= 16'h0;
         end else if (start && decKind != dcfd_pkg::K_BUFRD) begin
            // RL18: immediate zero response
            respValid_ff <= 1'b1;
            resp0_ff <= 16'h0;
            resp1_ff <= 16'h0;
         end else if (state_ff == dcfd_pkg::ST_DELAY && dlyCnt_ff == 8'h0) begin
            // RL15: delayed zero parcels
            respValid_ff <= 1'b1;
            resp0_ff <= 16'h0;
            resp1_ff <= 16'h0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drvStatus_ff <= 16'h0;
      end else if (drvDone && (state_ff == dcfd_pkg::ST_WAIT
            || state_ff == dcfd_pkg::ST_XFER)) begin
         // RL20: latch bus-in
         drvStatus_ff <= drvS3_ff.busIn;
      end else if (start && decKind == dcfd_pkg::K_CTLSTS) begin
         drvStatus_ff <= 16'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (state_ff != dcfd_pkg::ST_IDLE) || start;
      end
   end
endmodule

// ### rtl/dcfd_pkg.sv
// Purpose: shared constants and types for the disk channel function decoder
// Assumes: 125 MHz core clock
// Notes: function codes are eight-bit selectors written in octal
package dcfd_pkg;
   // ==========================================================
   // timing
   localparam int CLK_NS = 8;
   localparam int SAMPLE_NS = 8;
   localparam int WCLK_PERIOD_NS = 80;
   localparam int WCLK_HALF_CYC = (WCLK_PERIOD_NS / 2) / CLK_NS;
   localparam int RESP_DELAY_CYC = 16;
   // ==========================================================
   // parcel layout
   localparam logic [2:0] HDR_PREFIX = 3'h3;
   localparam int HDR_PREFIX_LSB = 13;
   localparam int NODE_LSB = 9;
   localparam int LONG_PARCELS = 2048;
   localparam int SHORT_PARCELS = 16;
   localparam logic [15:0] RESERVE_KEY = 16'h0554;
   // ==========================================================
   // four-bit drive command codes
   localparam logic [3:0] DC_RELEASE = 4'hf;
   localparam logic [3:0] DC_RELOPP = 4'he;
   localparam logic [3:0] DC_SELECT = 4'h1;
   localparam logic [3:0] DC_CLRFLT = 4'hc;
   localparam logic [3:0] DC_RESET = 4'hb;
   localparam logic [3:0] DC_RTZ = 4'hd;
   localparam logic [3:0] DC_SELSTS = 4'h7;
   localparam logic [3:0] DC_GENSTS = 4'h8;
   localparam logic [3:0] DC_DIAG = 4'h9;
   localparam logic [3:0] DC_CYL = 4'h5;
   localparam logic [3:0] DC_HEAD = 4'h4;
   localparam logic [3:0] DC_READ = 4'h2;
   localparam logic [3:0] DC_WRITE = 4'h3;
   localparam logic [3:0] DC_ECHO = 4'h0;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_CMD = 6'h02,
      ST_XFER = 6'h04,
      ST_WAIT = 6'h08,
      ST_DELAY = 6'h10,
      ST_ECHO = 6'h20
   } dcfd_state_e;

   typedef enum logic [2:0] {
      K_NONE = 3'h0,
      K_DRIVE = 3'h1,
      K_CTLSTS = 3'h2,
      K_BUFRD = 3'h3,
      K_BUFECHO = 3'h4
   } dcfd_kind_e;

   typedef struct packed {
      logic [15:0] p0;
      logic [15:0] p1;
      logic [15:0] p3;
   } dcfd_req_s;

   typedef struct packed {
      logic ready;
      logic done;
      logic error;
      logic [15:0] busIn;
   } dcfd_drv_s;
endpackage

// ### sim/dcfd_drive_model.sv
// Purpose: behavioural disk drive on the far side of the decoder
// Assumes: read clock runs free, also between commands
// Notes: released bus-in shows the inverse of its last value
`timescale 1ns/10ps
module dcfd_drive_model (
   input wire logic funcReady,
   input wire logic [7:0] nData,
   input wire logic [7:0] nWait,
   input wire logic [15:0] stsWord,
   output logic readClk,
   output dcfd_pkg::dcfd_drv_s drv
);
   // odd phase offset keeps read clock edges off the core clock edges
   initial begin
      readClk = 1'b0;
      drv = '0;
      #0.3;
      forever #62.5 readClk = ~readClk;
   end
   // ==========================================================
   // command service
   always @(posedge funcReady) begin
      repeat (nWait + 1) @(posedge readClk);
      for (int i = 0; i < nData; i++) begin
         drv.ready = 1'b1;
         drv.busIn = 16'(i);
         @(posedge readClk);
         drv.ready = 1'b0;
         drv.busIn = ~drv.busIn;
         @(posedge readClk);
      end
      drv.ready = 1'b1;
      drv.done = 1'b1;
      drv.busIn = stsWord;
      @(posedge readClk);
      drv.ready = 1'b0;
      drv.done = 1'b0;
      drv.busIn = ~stsWord;
   end
endmodule

// ### sim/dcfd_top_sva.sv
// Purpose: port-level checks of the disk channel function decoder
// Assumes: latencies as settled in the hand-over contract
// Notes: read clock checks wait until the sampler history is full
`timescale 1ns/10ps
module dcfd_top_sva #(
   parameter logic [3:0] NODE_ADDR = 4'h0,
   parameter int LONG_COUNT = dcfd_pkg::LONG_PARCELS,
   parameter int SHORT_COUNT = dcfd_pkg::SHORT_PARCELS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic secondType,
   input wire logic reqValid,
   input wire dcfd_pkg::dcfd_req_s req,
   input wire logic callPulse,
   input wire logic readClk,
   input wire dcfd_pkg::dcfd_drv_s drv,
   input wire logic respValid_ff,
   input wire logic [15:0] resp0_ff,
   input wire logic [15:0] resp1_ff,
   input wire logic callReady_ff,
   input wire logic [15:0] callResp_ff,
   input wire logic busy_ff,
   input wire logic echoMode_ff,
   input wire logic writeClk_ff,
   input wire logic funcReady_ff,
   input wire logic [3:0] funcCode_ff,
   input wire logic [15:0] busOut_ff,
   input wire logic rdStrobe_ff,
   input wire logic [15:0] drvStatus_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic take;
   logic drvFn_ff;
   logic [4:0] hi;
   logic [3:0] upCnt_ff;
   logic [3:0] sinceDone_ff;
   assign hi = req.p0[7:3];
   assign take = reqValid && !busy_ff && req.p0[15:9] == {dcfd_pkg::HDR_PREFIX, NODE_ADDR};
   // helper counters: time since reset, time since done, drive command seen
   always_ff @(posedge clk) begin
      if (!rst_n) upCnt_ff <= '0;
      else if (upCnt_ff != 4'hf) upCnt_ff <= upCnt_ff + 4'h1;
      if (!rst_n) sinceDone_ff <= 4'hf;
      else if (drv.done) sinceDone_ff <= '0;
      else if (sinceDone_ff != 4'hf) sinceDone_ff <= sinceDone_ff + 4'h1;
      if (!rst_n || take) drvFn_ff <= 1'b0;
      else if (funcReady_ff) drvFn_ff <= 1'b1;
   end
   // ==========================================================
   // assertions
   resp_zero_a: assert property (take && hi != 5'h15 |=> respValid_ff &&
      (hi == 5'h06 || (resp0_ff == 16'h0000 && resp1_ff == 16'h0000)))
      else $error("no zero response after request");
   ctl_status_a: assert property (take && hi == 5'h06 |=> resp0_ff == $past(drvStatus_ff))
      else $error("controller status parcel wrong");
   bufrd_delay_a: assert property (take && hi == 5'h15 |=> !respValid_ff [*8]
      ##9 (respValid_ff && resp0_ff == 16'h0000 && resp1_ff == 16'h0000))
      else $error("buffer read response not delayed");
   echo_set_a: assert property (take && hi == 5'h1e |-> ##[1:3] echoMode_ff)
      else $error("echo mode not entered");
   call_clear_a: assert property (callPulse |=> !echoMode_ff && !callReady_ff)
      else $error("call pulse did not clear");
   done_ready_a: assert property ($rose(callReady_ff) && drvFn_ff |-> sinceDone_ff < 4'hc)
      else $error("call ready without drive done");
   wclk_high_a: assert property ($rose(writeClk_ff) |=> writeClk_ff [*4] ##1 !writeClk_ff)
      else $error("write clock high phase wrong");
   wclk_low_a: assert property ($fell(writeClk_ff) |=> !writeClk_ff [*4] ##1 writeClk_ff)
      else $error("write clock low phase wrong");
   edge_strobe_a: assert property ($fell(readClk) && upCnt_ff == 4'hf |-> ##[2:7] rdStrobe_ff)
      else $error("read clock fall missed");
   strobe_one_a: assert property (rdStrobe_ff |=> !rdStrobe_ff)
      else $error("capture strobe too wide");
   func_width_a: assert property ($rose(funcReady_ff) |-> funcReady_ff [*8] ##3 !funcReady_ff)
      else $error("function ready width wrong");
   hdr_refuse_a: assert property (reqValid && !busy_ff &&
      req.p0[15:9] != {dcfd_pkg::HDR_PREFIX, NODE_ADDR} |=> !respValid_ff)
      else $error("bad header answered");
   bufrd_c: cover property (take && hi == 5'h15);
   echo_c: cover property (take && hi == 5'h1e);
   ready_c: cover property ($rose(callReady_ff) && drvFn_ff);
endmodule
bind dcfd_top dcfd_top_sva #(.NODE_ADDR(NODE_ADDR), .LONG_COUNT(LONG_COUNT),
   .SHORT_COUNT(SHORT_COUNT)) chk (.*);

// ### sim/disk_channel_function_decoder_tb.sv
// Purpose: self-checking bench for the disk channel function decoder
// Assumes: drive model answers every drive command
// Notes: sweeps every selector under both drive types, random parcels
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
$display("mismatch %s exp %h got %h", nm, e, g); end end
module disk_channel_function_decoder_tb;
   localparam logic [3:0] NODE = 4'h5;
   localparam int LONGN = 4;
   localparam int SHORTN = 2;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic secondType = 1'b0;
   logic reqValid = 1'b0;
   logic callPulse = 1'b0;
   logic seen, stsOk;
   dcfd_pkg::dcfd_req_s req = '0;
   dcfd_pkg::dcfd_drv_s drv;
   logic readClk, respValid_ff, callReady_ff, busy_ff, echoMode_ff;
   logic writeClk_ff, funcReady_ff, rdStrobe_ff;
   logic [3:0] funcCode_ff;
   logic [15:0] resp0_ff, resp1_ff, callResp_ff, busOut_ff, drvStatus_ff, expSts;
   logic [15:0] stsWord = 16'h0000;
   logic [7:0] nData = 8'h00;
   logic [7:0] nWait = 8'h00;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int seed = 32'h274b;
   dcfd_top #(.NODE_ADDR(NODE), .LONG_COUNT(LONGN), .SHORT_COUNT(SHORTN)) DUT (.*);
   dcfd_drive_model drive (.funcReady(funcReady_ff), .nData(nData), .nWait(nWait),
      .stsWord(stsWord), .readClk(readClk), .drv(drv));
   always #4 clk = ~clk;
   // run length is about 16k cycles, so this ceiling only catches a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================================
   // expectation: bit 6 command sent, bits 5:4 long/short, bits 3:0 code
   function automatic logic [6:0] expOf(input logic [7:0] s, input logic t2);
      logic [2:0] lo;
      lo = s[2:0];
      expOf = '0;
      case (s[7:3])
         5'h00: if (lo < 3'h2) expOf = {3'h4, lo[0] ? dcfd_pkg::DC_RELOPP : dcfd_pkg::DC_RELEASE};
         5'h01: expOf = {3'h4, dcfd_pkg::DC_SELECT};
         5'h02: if (lo < 3'h2) expOf = {3'h4, lo[0] ? dcfd_pkg::DC_RESET : dcfd_pkg::DC_CLRFLT};
         5'h03: expOf = {3'h4, dcfd_pkg::DC_RTZ};
         5'h04: expOf = {3'h4, dcfd_pkg::DC_SELSTS};
         5'h05: expOf = {3'h4, dcfd_pkg::DC_GENSTS};
         5'h07: expOf = {3'h4, dcfd_pkg::DC_DIAG};
         5'h08: if (lo < 3'h2) expOf = {3'h4, lo[0] ? dcfd_pkg::DC_HEAD : dcfd_pkg::DC_CYL};
         5'h10: if (lo < 3'h6 || (lo == 3'h6 && t2))
            expOf = {(lo == 3'h0 || lo == 3'h2) ? 3'h6 : 3'h5, dcfd_pkg::DC_READ};
         5'h11: if (t2 && (lo == 3'h0 || lo == 3'h2)) expOf = {3'h6, dcfd_pkg::DC_READ};
         5'h18: if (lo < 3'h5 || (lo == 3'h6 && t2))
            expOf = {(lo == 3'h0 || lo == 3'h4) ? 3'h6 : 3'h5, dcfd_pkg::DC_WRITE};
         5'h19: if (t2 && (lo == 3'h0 || lo == 3'h4)) expOf = {3'h6, dcfd_pkg::DC_WRITE};
         5'h1f: expOf = {3'h4, dcfd_pkg::DC_ECHO};
         default: ;
      endcase
   endfunction
   task automatic runFn(input logic [7:0] sel);
      logic [6:0] e;
      int k;
      e = expOf(sel, secondType);
      nData = e[5] ? 8'(LONGN) : (e[4] ? 8'(SHORTN) : 8'h00);
      nWait = 8'({$random(seed)} % 3);
      stsWord = 16'($random(seed));
      req.p0 = {dcfd_pkg::HDR_PREFIX, NODE, 1'($random(seed)), sel};
      req.p1 = 16'($random(seed));
      req.p3 = (sel[7:4] == 4'h0) ? dcfd_pkg::RESERVE_KEY : 16'($random(seed));
      reqValid = 1'b1;
      for (k = 0; k < 40 && respValid_ff !== 1'b1; k++) begin
         @(negedge clk);
         reqValid = 1'b0;
      end
      `CHK("resp delay", (sel[7:3] == 5'h15) ? 1 + dcfd_pkg::RESP_DELAY_CYC : 1, k)
      if (sel[7:3] != 5'h06) `CHK("resp parcels", 32'h0, {resp0_ff, resp1_ff})
      else if (stsOk) `CHK("ctl status", expSts, resp0_ff)
      // reading controller status clears the holding register
      if (sel[7:3] == 5'h06) expSts = 16'h0;
      if (e[6] === 1'b1) begin
         for (k = 0; k < 40 && funcReady_ff !== 1'b1; k++) @(negedge clk);
         `CHK("func code", e[3:0], funcCode_ff)
         `CHK("bus out", req.p3, busOut_ff)
         `CHK("busy", 1'b1, busy_ff)
         for (k = 0; k < 800 && callReady_ff !== 1'b1; k++) @(negedge clk);
         `CHK("call ready", 1'b1, callReady_ff)
         `CHK("drive status", stsWord, drvStatus_ff)
         `CHK("call resp", req.p1, callResp_ff)
         expSts = stsWord;
         stsOk = 1'b1;
      end else begin
         seen = 1'b0;
         repeat (14) begin
            @(negedge clk);
            seen |= funcReady_ff;
         end
         `CHK("no command", 1'b0, seen)
         if (sel[7:3] == 5'h1e) `CHK("echo mode", 1'b1, echoMode_ff)
      end
      callPulse = 1'b1;
      @(negedge clk);
      callPulse = 1'b0;
      @(negedge clk);
      `CHK("call clear", 2'b00, {echoMode_ff, callReady_ff})
      for (k = 0; k < 40 && busy_ff !== 1'b0; k++) @(negedge clk);
   endtask
   initial begin
      stsOk = 1'b1;
      expSts = 16'h0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 2; i++) begin
         req.p0 = i ? {3'h2, NODE, 9'h000} : {dcfd_pkg::HDR_PREFIX, ~NODE, 9'h000};
         reqValid = 1'b1;
         seen = 1'b0;
         repeat (6) begin
            @(negedge clk);
            if (reqValid) reqValid = 1'b0;
            seen |= respValid_ff;
         end
         `CHK("bad header", 1'b0, seen)
      end
      for (int i = 0; i < 512; i++) begin
         secondType = i[8];
         runFn(i[7:0]);
      end
      final_report();
   end
endmodule
